/* rfc_pkg.sv */
package rfc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] TX_SETUP_ADDR  = 8'h2C;
    localparam logic [7:0] RX_SETUP_ADDR  = 8'h2D;
    localparam logic [7:0] FRAME_LEN_ADDR = 8'h2E;

    // Reset values and writable bits (reserved bits read zero)
    localparam logic [7:0] TX_SETUP_RST   = 8'h00;
    localparam logic [7:0] RX_SETUP_RST   = 8'h00;
    localparam logic [7:0] FRAME_LEN_RST  = 8'h00;
    localparam logic [7:0] TX_SETUP_MASK  = 8'h7F;
    localparam logic [7:0] RX_SETUP_MASK  = 8'hFF;
    localparam logic [7:0] FRAME_LEN_MASK = 8'h1F;

    // Field positions
    localparam int COPY_BIT     = 7;
    localparam int SEED_LSB     = 4;
    localparam int KIND_LSB     = 2;
    localparam int INVERT_BIT   = 1;
    localparam int ENABLE_BIT   = 0;
    localparam int GRID_BIT     = 4;
    localparam int PAYLOAD_BIT  = 3;
    localparam int LASTBITS_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Check kinds
    typedef enum logic [1:0] {
        KIND_CRC5,
        KIND_CRC8,
        KIND_CRC16,
        KIND_RSVD
    } rfc_kind_t;

    // Seed codes
    localparam logic [2:0] SEED_C0   = 3'h0;
    localparam logic [2:0] SEED_C1   = 3'h1;
    localparam logic [2:0] SEED_C2   = 3'h2;
    localparam logic [2:0] SEED_C3   = 3'h3;
    localparam logic [2:0] SEED_USER = 3'h6;
    localparam logic [2:0] SEED_C7   = 3'h7;

    // Seed values
    localparam logic [15:0] CRC16_SEED1 = 16'h6363;
    localparam logic [15:0] CRC16_SEED2 = 16'hA671;
    localparam logic [15:0] CRC16_SEED3 = 16'hFFFE;
    localparam logic [15:0] CRC16_SEED7 = 16'hFFFF;
    localparam logic [7:0]  CRC8_SEED1  = 8'h12;
    localparam logic [7:0]  CRC8_SEED2  = 8'hBF;
    localparam logic [7:0]  CRC8_SEED3  = 8'hFD;
    localparam logic [7:0]  CRC8_SEED7  = 8'hFF;
    localparam logic [4:0]  CRC5_SEED1  = 5'h12;
    localparam logic [4:0]  CRC5_SEED7  = 5'h1F;

    // Reflected polynomials (x16+x12+x5+1, x8+x4+x3+x2+1, x5+x3+1)
    localparam logic [15:0] POLY16_REV = 16'h8408;
    localparam logic [7:0]  POLY8_REV  = 8'hB8;
    localparam logic [4:0]  POLY5_REV  = 5'h12;

    // Width masks
    localparam logic [15:0] MASK16 = 16'hFFFF;
    localparam logic [15:0] MASK8  = 16'h00FF;
    localparam logic [15:0] MASK5  = 16'h001F;

    ////////////////////////////////////////////////////////////////////////
    // Timing: one elementary time unit at 125 MHz
    localparam int CLK_MHZ    = 125;
    localparam int ETU_NS     = 9440;
    localparam int ETU_CYCLES = (ETU_NS * CLK_MHZ) / 1000;

    // Bytes a check occupies on the air
    function automatic logic [1:0] crc_bytes(input logic [1:0] kind);
        case (kind)
            KIND_CRC16: crc_bytes = 2'd2;
            KIND_CRC8:  crc_bytes = 2'd1;
            KIND_CRC5:  crc_bytes = 2'd1;
            default:    crc_bytes = 2'd0;
        endcase
    endfunction

    // Significant bits of a check value
    function automatic logic [15:0] crc_mask(input logic [1:0] kind);
        case (kind)
            KIND_CRC16: crc_mask = MASK16;
            KIND_CRC8:  crc_mask = MASK8;
            default:    crc_mask = MASK5;
        endcase
    endfunction

endpackage

/* rfc_ser_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Byte-to-bit serializer hookup
interface rfc_ser_if;
    logic       load;      // Take a byte
    logic [7:0] byte_v;    // Byte to send
    logic [3:0] nbits;     // Bits of it to send, LSB first
    logic       tick;      // One bit per tick
    logic       busy;      // Bits still pending
    logic       bit_out;   // Current bit
    logic       bit_valid; // One-cycle bit strobe
    modport ctrl (output load, byte_v, nbits, tick, input busy, bit_out, bit_valid);
    modport ser  (input load, byte_v, nbits, tick, output busy, bit_out, bit_valid);
endinterface
`default_nettype wire

/* rfc_crc_step.sv */
`timescale 1ns/1ns
`default_nettype none
// Advance a reflected check register over up to eight data bits
module rfc_crc_step
    import rfc_pkg::*;
(
    // Operands
    input  wire logic [1:0]  kind,
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    input  wire logic [3:0]  nbits,
    // Result
    output logic      [15:0] crc_out
);
    logic [15:0] poly; // Polynomial for the kind

    ////////////////////////////////////////////////////////////////////////
    // Bit-serial LFSR, LSB first, only the leading nbits are folded in
    always_comb begin
        case (kind)
            KIND_CRC16: poly = POLY16_REV;
            KIND_CRC8:  poly = {8'h00, POLY8_REV};
            default:    poly = {11'h000, POLY5_REV};
        endcase
        crc_out = crc_in & crc_mask(kind);
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nbits) begin
                if (crc_out[0] ^ data[i]) begin
                    crc_out = (crc_out >> 1) ^ poly;
                end else begin
                    crc_out = crc_out >> 1;
                end
            end
        end
    end
endmodule // rfc_crc_step
`default_nettype wire

/* rfc_serializer.sv */
`timescale 1ns/1ns
`default_nettype none
// Shifts one byte out LSB first, one bit per tick
module rfc_serializer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Controller side
    rfc_ser_if.ser    sif
);
    typedef struct packed {
        logic       busy;
        logic [7:0] sh;
        logic [3:0] left;
        logic       bit_out;
        logic       bit_valid;
    } rfc_ser_st_t;

    rfc_ser_st_t s_r;   // Current state
    rfc_ser_st_t s_nxt; // Next state

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_nxt           = s_r;
        s_nxt.bit_valid = 1'b0;
        if (sif.load) begin
            // Partial bytes just stop early: upper bits never leave
            s_nxt.sh   = sif.byte_v;
            s_nxt.left = sif.nbits;
            s_nxt.busy = (sif.nbits != 4'd0);
        end else if (s_r.busy && sif.tick) begin
            s_nxt.bit_out   = s_r.sh[0];
            s_nxt.bit_valid = 1'b1;
            s_nxt.sh        = s_r.sh >> 1;
            s_nxt.left      = s_r.left - 4'd1;
            s_nxt.busy      = (s_r.left != 4'd1);
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.busy      = s_r.busy;
    assign sif.bit_out   = s_r.bit_out;
    assign sif.bit_valid = s_r.bit_valid;
endmodule // rfc_serializer
`default_nettype wire

/* rfc_frame_crc.sv */
`timescale 1ns/1ns
`default_nettype none
module rfc_frame_crc
    import rfc_pkg::*;
#(
    parameter int ETU_LEN = ETU_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Nonvolatile user presets
    input  wire logic [15:0] user_seed16,
    input  wire logic [7:0]  user_seed8,
    input  wire logic [4:0]  user_seed5,
    // Transmit byte stream
    input  wire logic        tx_start,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_byte_valid,
    input  wire logic        tx_byte_last,
    output logic             tx_byte_ready,
    // Transmit bit stream
    output logic             tx_bit,
    output logic             tx_bit_valid,
    output logic             tx_symbol,
    output logic             tx_done,
    // Receive byte stream
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_byte_valid,
    input  wire logic        rx_byte_last,
    input  wire logic        rx_error_clear,
    // Receive results
    output logic      [7:0]  fifo_data,
    output logic             fifo_wr,
    output logic             rx_crc_error,
    output logic             rx_done
);
    if (ETU_LEN < 2 || ETU_LEN > 65535) begin : g_chk
        $error("ETU_LEN out of range");
    end

    typedef enum logic [2:0] {TX_IDLE, TX_GRID, TX_DATA, TX_CRC, TX_SYM, TX_END} rfc_tx_st_t;

    typedef struct packed {
        logic [7:0]  tx_setup;   // Transmit check setup
        logic [7:0]  rx_setup;   // Receive check setup
        logic [7:0]  frame_len;  // Transmit frame length
        logic [7:0]  rdata;      // Read data
        rfc_tx_st_t  tx_st;      // Transmit sequencer
        logic        sym_mode;   // Lone symbol requested
        logic [15:0] etu_cnt;    // ETU phase
        logic        tick;       // ETU boundary strobe
        logic [15:0] tx_crc;     // Running transmit check
        logic [1:0]  crc_idx;    // Check bytes sent
        logic        ready;      // Byte accept
        logic        sym;        // Symbol strobe
        logic        done;       // Frame sent
        logic [15:0] rx_crc;     // Running receive check
        logic        in_frame;   // Receiving
        logic [7:0]  h0;         // Newest held byte
        logic [7:0]  h1;         // Older held byte
        logic [1:0]  hcnt;       // Held byte count
        logic [1:0]  drain;      // Check bytes to copy out
        logic [7:0]  fdata;      // FIFO byte
        logic        fwr;        // FIFO strobe
        logic        err;        // Check error flag
        logic        rdone;      // Frame received
    } rfc_st_t;

    rfc_st_t     s_r;        // Current state
    rfc_st_t     s_nxt;      // Next state
    rfc_ser_if   sif ();     // Serializer link
    logic [15:0] tx_step;    // Transmit check after accepted byte
    logic [15:0] rx_step;    // Receive check after popped byte
    logic [7:0]  rx_pop;     // Byte leaving the hold line
    logic [3:0]  tx_nb;      // Bits of the accepted byte

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Seed lookup shared by both directions
    function automatic logic [15:0] seed_of(input logic [1:0] kind, input logic [2:0] code,
                                            input logic [15:0] u16, input logic [7:0] u8,
                                            input logic [4:0] u5);
        logic [15:0] v;
        v = 16'h0000;
        if (code == SEED_USER) begin
            case (kind)
                KIND_CRC16: v = u16;
                KIND_CRC8:  v = {8'h00, u8};
                default:    v = {11'h000, u5};
            endcase
        end else if (kind == KIND_CRC16) begin
            case (code)
                SEED_C1: v = CRC16_SEED1;
                SEED_C2: v = CRC16_SEED2;
                SEED_C3: v = CRC16_SEED3;
                SEED_C7: v = CRC16_SEED7;
                default: v = 16'h0000;
            endcase
        end else if (kind == KIND_CRC8) begin
            case (code)
                SEED_C1: v = {8'h00, CRC8_SEED1};
                SEED_C2: v = {8'h00, CRC8_SEED2};
                SEED_C3: v = {8'h00, CRC8_SEED3};
                SEED_C7: v = {8'h00, CRC8_SEED7};
                default: v = 16'h0000;
            endcase
        end else begin
            case (code)
                SEED_C1: v = {11'h000, CRC5_SEED1};
                SEED_C7: v = {11'h000, CRC5_SEED7};
                default: v = 16'h0000;
            endcase
        end
        return v;
    endfunction

    // Final check value, inverted on request and cut to width
    function automatic logic [15:0] crc_final(input logic [1:0] kind, input logic inv,
                                              input logic [15:0] c);
        return (inv ? ~c : c) & crc_mask(kind);
    endfunction

    // Field views
    logic [1:0] tx_kind;
    logic [1:0] rx_kind;
    logic [2:0] last_bits;   // Final byte bit count
    logic [1:0] rx_clen;     // Check bytes expected
    assign tx_kind   = s_r.tx_setup[KIND_LSB +: 2];
    assign rx_kind   = s_r.rx_setup[KIND_LSB +: 2];
    assign last_bits = s_r.frame_len[LASTBITS_LSB +: 3];
    // Check bytes are held back only while checking is on
    assign rx_clen   = s_r.rx_setup[ENABLE_BIT] ? crc_bytes(rx_kind) : 2'd0;

    // Bit count of accepted byte
    assign tx_nb = (tx_byte_last && last_bits != 3'd0) ? {1'b0, last_bits} : 4'd8;

    // Byte leaving the hold line
    assign rx_pop = (rx_clen == 2'd0) ? rx_byte : ((rx_clen == 2'd2) ? s_r.h1 : s_r.h0);

    ////////////////////////////////////////////////////////////////////////
    // Check engines
    rfc_crc_step u_tx_crc (
        .kind    (tx_kind),
        .crc_in  (s_r.tx_crc),
        .data    (tx_byte),
        .nbits   (tx_nb),
        .crc_out (tx_step)
    );

    rfc_crc_step u_rx_crc (
        .kind    (rx_kind),
        .crc_in  (s_r.rx_crc),
        .data    (rx_pop),
        .nbits   (4'd8),
        .crc_out (rx_step)
    );

    rfc_serializer u_ser (
        .clk    (clk),
        .resetn (resetn),
        .sif    (sif.ser)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [15:0] tfin;   // Transmit check to append
        logic [15:0] rfin;   // Receive check computed
        logic [15:0] rgot;   // Receive check on the air
        logic [7:0]  n0;     // Hold line after push
        logic [7:0]  n1;     // Hold line after push
        logic        full;   // Hold line has a full check
        s_nxt        = s_r;
        s_nxt.sym    = 1'b0;
        s_nxt.done   = 1'b0;
        s_nxt.fwr    = 1'b0;
        s_nxt.rdone  = 1'b0;
        s_nxt.ready  = 1'b0;
        sif.load     = 1'b0;
        sif.byte_v   = tx_byte;
        sif.nbits    = tx_nb;
        sif.tick     = s_r.tick;
        tfin         = crc_final(tx_kind, s_r.tx_setup[INVERT_BIT], s_r.tx_crc);
        rfin         = 16'h0000;
        rgot         = 16'h0000;
        n0           = rx_byte;
        n1           = s_r.h0;
        full         = 1'b0;

        // Register writes, reserved bits held at zero
        if (reg_wr) begin
            case (reg_addr)
                TX_SETUP_ADDR:  s_nxt.tx_setup  = reg_wdata & TX_SETUP_MASK;
                RX_SETUP_ADDR:  s_nxt.rx_setup  = reg_wdata & RX_SETUP_MASK;
                FRAME_LEN_ADDR: s_nxt.frame_len = reg_wdata & FRAME_LEN_MASK;
                default:        ;
            endcase
        end

        // Registered read, unmapped reads zero
        case (reg_addr)
            TX_SETUP_ADDR:  s_nxt.rdata = s_r.tx_setup;
            RX_SETUP_ADDR:  s_nxt.rdata = s_r.rx_setup;
            FRAME_LEN_ADDR: s_nxt.rdata = s_r.frame_len;
            default:        s_nxt.rdata = 8'h00;
        endcase

        // Free-running ETU phase, one tick per unit
        s_nxt.tick = (s_r.etu_cnt == 16'(ETU_LEN - 1));
        s_nxt.etu_cnt = s_nxt.tick ? 16'h0000 : s_r.etu_cnt + 16'd1;

        // Transmit sequencer
        case (s_r.tx_st)
            TX_IDLE: begin
                if (tx_start) begin
                    s_nxt.tx_crc   = seed_of(tx_kind, s_r.tx_setup[SEED_LSB +: 3],
                                             user_seed16, user_seed8, user_seed5);
                    s_nxt.crc_idx  = 2'd0;
                    s_nxt.sym_mode = !s_r.frame_len[PAYLOAD_BIT];
                    if (s_r.frame_len[GRID_BIT]) begin
                        // Hold until the running grid comes round
                        s_nxt.tx_st = TX_GRID;
                    end else begin
                        // Off-grid start: restart the phase here
                        s_nxt.etu_cnt = 16'h0000;
                        s_nxt.tick    = 1'b0;
                        s_nxt.tx_st   = s_r.frame_len[PAYLOAD_BIT] ? TX_DATA : TX_SYM;
                    end
                end
            end
            TX_GRID: begin
                if (s_r.tick) begin
                    s_nxt.tx_st = s_r.sym_mode ? TX_SYM : TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_byte_valid && s_r.ready) begin
                    sif.load     = 1'b1;
                    s_nxt.tx_crc = tx_step;
                    if (tx_byte_last) begin
                        if (s_r.tx_setup[ENABLE_BIT] && crc_bytes(tx_kind) != 2'd0) begin
                            s_nxt.tx_st = TX_CRC;
                        end else begin
                            s_nxt.tx_st = TX_END;
                        end
                    end
                end else begin
                    s_nxt.ready = !sif.busy;
                end
            end
            TX_CRC: begin
                if (!sif.busy) begin
                    sif.load = 1'b1;
                    // Low byte first; CRC5 goes out as five bits
                    sif.byte_v = (s_r.crc_idx == 2'd0) ? tfin[7:0] : tfin[15:8];
                    sif.nbits  = (tx_kind == KIND_CRC5) ? 4'd5 : 4'd8;
                    s_nxt.crc_idx = s_r.crc_idx + 2'd1;
                    if (s_r.crc_idx + 2'd1 == crc_bytes(tx_kind)) begin
                        s_nxt.tx_st = TX_END;
                    end
                end
            end
            TX_SYM: begin
                if (s_r.tick) begin
                    s_nxt.sym   = 1'b1;
                    s_nxt.done  = 1'b1;
                    s_nxt.tx_st = TX_IDLE;
                end
            end
            TX_END: begin
                if (!sif.busy) begin
                    s_nxt.done  = 1'b1;
                    s_nxt.tx_st = TX_IDLE;
                end
            end
            default: s_nxt.tx_st = TX_IDLE;
        endcase

        // Receive: seed stays loaded between frames
        if (!s_r.in_frame) begin
            s_nxt.rx_crc = seed_of(rx_kind, s_r.rx_setup[SEED_LSB +: 3],
                                   user_seed16, user_seed8, user_seed5);
            s_nxt.hcnt   = 2'd0;
        end

        // Clear comes first so that a same-cycle error still sets the flag
        if (rx_error_clear) begin
            s_nxt.err = 1'b0;
        end
        if (s_r.drain != 2'd0) begin
            // Copy held check bytes out, oldest first
            s_nxt.fwr   = 1'b1;
            s_nxt.fdata = (s_r.drain == 2'd2) ? s_r.h1 : s_r.h0;
            s_nxt.drain = s_r.drain - 2'd1;
        end else if (rx_byte_valid) begin
            s_nxt.in_frame = !rx_byte_last;
            full = (s_r.hcnt == rx_clen);
            // Data leaves the hold line once a full check sits behind it
            if (full || !s_r.in_frame && rx_clen == 2'd0) begin
                s_nxt.rx_crc = rx_step;
                s_nxt.fwr    = 1'b1;
                s_nxt.fdata  = rx_pop;
            end else begin
                s_nxt.hcnt = s_r.hcnt + 2'd1;
            end
            s_nxt.h0 = n0;
            s_nxt.h1 = n1;
            if (rx_byte_last) begin
                s_nxt.rdone = 1'b1;
                rfin = crc_final(rx_kind, s_r.rx_setup[INVERT_BIT],
                                 (full || rx_clen == 2'd0) ? rx_step : s_r.rx_crc);
                rgot = ((rx_clen == 2'd2) ? {n0, n1} : {8'h00, n0}) & crc_mask(rx_kind);
                if (s_r.rx_setup[ENABLE_BIT] && rx_clen != 2'd0) begin
                    // Short frame or mismatch raises the flag
                    if (!full && s_r.hcnt + 2'd1 < rx_clen || rfin != rgot) begin
                        s_nxt.err = 1'b1;
                    end
                end
                if (s_r.rx_setup[COPY_BIT] && rx_clen != 2'd0) begin
                    s_nxt.drain = rx_clen;
                end
            end
        end

    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r           <= '0;
            s_r.tx_setup  <= TX_SETUP_RST;
            s_r.rx_setup  <= RX_SETUP_RST;
            s_r.frame_len <= FRAME_LEN_RST;
            s_r.tx_st     <= TX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign reg_rdata     = s_r.rdata;
    assign tx_byte_ready = s_r.ready;
    assign tx_bit        = sif.bit_out;
    assign tx_bit_valid  = sif.bit_valid;
    assign tx_symbol     = s_r.sym;
    assign tx_done       = s_r.done;
    assign fifo_data     = s_r.fdata;
    assign fifo_wr       = s_r.fwr;
    assign rx_crc_error  = s_r.err;
    assign rx_done       = s_r.rdone;
endmodule // rfc_frame_crc
`default_nettype wire

/* rfc_frame_crc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the frame check block
module rfc_frame_crc_checker
    import rfc_pkg::*;
#(parameter int ETU_LEN = ETU_CYCLES) (
    // Watched inputs and outputs
    input wire logic       clk, resetn, reg_wr, tx_bit_valid, tx_symbol, tx_done,
    input wire logic       rx_byte_valid, rx_byte_last, rx_error_clear, rx_crc_error, rx_done,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
    int gap_r; // Cycles since the last bit, saturating so idle gaps pass
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) gap_r <= ETU_LEN;
        else gap_r <= tx_bit_valid ? 1 : gap_r + (gap_r < ETU_LEN);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Write then hold the address: readback two cycles on
    sequence wr_s; reg_wr && reg_addr == TX_SETUP_ADDR ##1 !reg_wr && reg_addr == TX_SETUP_ADDR; endsequence
    read_back_a: assert property (wr_s |=> reg_rdata == ($past(reg_wdata, 2) & TX_SETUP_MASK))
        else $error("setup readback wrong");
    bit_spacing_a: assert property (tx_bit_valid |-> gap_r == ETU_LEN)
        else $error("bit spacing wrong");
    symbol_alone_a: assert property (tx_symbol |-> tx_done && !tx_bit_valid)
        else $error("symbol not alone");
    tx_done_pulse_a: assert property (tx_done |=> !tx_done)
        else $error("tx done stuck");
    rx_done_due_a: assert property (rx_byte_valid && rx_byte_last |=> rx_done ##1 !rx_done)
        else $error("rx done misplaced");
    error_cause_a: assert property ($rose(rx_crc_error) |-> rx_done)
        else $error("error without frame end");
    error_sticky_a: assert property ($fell(rx_crc_error) |-> $past(rx_error_clear))
        else $error("error flag dropped");
    error_clear_a: assert property (rx_error_clear && !(rx_byte_valid && rx_byte_last) |=> !rx_crc_error)
        else $error("error flag not cleared");
endmodule // rfc_frame_crc_checker
bind rfc_frame_crc rfc_frame_crc_checker #(.ETU_LEN(ETU_LEN)) i_chk (.*);
`default_nettype wire

/* rfc_card_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Card side: gathers bits from the air and answers with bytes
module rfc_card_model (
    input  wire logic       clk, tx_bit, tx_bit_valid,
    output logic      [7:0] rx_byte,
    output logic            rx_byte_valid, rx_byte_last
);
    logic heard[$]; // Air bits in arrival order, LSB first
    initial {rx_byte, rx_byte_valid, rx_byte_last} = '0;
    always @(posedge clk) if (tx_bit_valid) heard.push_back(tx_bit);
    // Back-to-back bytes; idle data line shows the inverse of the last byte
    task automatic answer(input logic [7:0] b[$]);
        foreach (b[i]) @(posedge clk) {rx_byte, rx_byte_valid, rx_byte_last} <= {b[i], 1'b1, i == b.size() - 1};
        @(posedge clk) {rx_byte, rx_byte_valid, rx_byte_last} <= {~rx_byte, 2'b00};
    endtask
endmodule // rfc_card_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the frame check block
module tb_top import rfc_pkg::*; ;
    logic clk = 0, resetn = 0, reg_wr = 0, tx_start = 0, tx_byte_valid = 0, tx_byte_last = 0, rx_error_clear = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, tx_byte = 0, reg_rdata, rx_byte, fifo_data, q[$];
    logic tx_byte_ready, tx_bit, tx_bit_valid, tx_symbol, tx_done, rx_byte_valid, rx_byte_last;
    logic fifo_wr, rx_crc_error, rx_done;
    int fails = 0, n_checks = 0;
    localparam logic [7:0] DB = 8'hB2; // Payload byte
    always #4 clk = ~clk;
    rfc_frame_crc #(.ETU_LEN(4)) i_dut (.*, .user_seed16(16'hC3A5), .user_seed8(8'h5A), .user_seed5(5'h0B));
    rfc_card_model i_card (.*);
    always @(posedge clk) if (fifo_wr) q.push_back(fifo_data);
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin fails++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic wreg(input logic [7:0] a, d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) reg_addr <= a;
        @(posedge clk) #1 d = reg_rdata;
    endtask
    // Bounded wait on a design strobe, read as sampled at the edge
    task automatic wait_for(ref logic s);
        int n = 0;
        do begin @(posedge clk); n++; end while (s !== 1'b1 && n < 400);
        chk("handshake", 1, s);
    endtask
    function automatic logic [15:0] nx(input logic [15:0] c, p, input logic b);
        return c[0] ^ b ? (c >> 1) ^ p : c >> 1;
    endfunction
    task automatic test_regs();
        logic [7:0] d, ad[4] = '{TX_SETUP_ADDR, RX_SETUP_ADDR, FRAME_LEN_ADDR, 8'h30}, ex[4] = '{8'h7F, 8'hFF, 8'h1F, 0};
        foreach (ad[i]) begin
            rreg(ad[i], d); chk("reset value", 0, d);
            wreg(ad[i], 8'hFF); rreg(ad[i], d); chk("readback", ex[i], d);
        end
        $display("register test done");
    endtask
    // One frame of one byte; the check is worked out here bit by bit
    task automatic tx_case(input logic [1:0] k, input logic [2:0] sc, input logic [15:0] sd, input logic inv, en,
                           input logic [7:0] fl);
        logic [15:0] c = sd, p;
        logic ex[$];
        int w = k == KIND_CRC16 ? 16 : k == KIND_CRC8 ? 8 : 5;
        p = k == KIND_CRC16 ? POLY16_REV : k == KIND_CRC8 ? {8'h0, POLY8_REV} : {11'h0, POLY5_REV};
        for (int i = 0; i < (fl[2:0] == 0 ? 8 : fl[2:0]); i++) begin ex.push_back(DB[i]); c = nx(c, p, DB[i]); end
        for (int i = 0; i < w * en; i++) ex.push_back(c[i] ^ inv);
        wreg(TX_SETUP_ADDR, {1'b0, sc, k, inv, en});
        wreg(FRAME_LEN_ADDR, fl);
        i_card.heard.delete();
        @(posedge clk) {tx_start, tx_byte, tx_byte_valid, tx_byte_last} <= {1'b1, DB, 2'b11};
        @(posedge clk) tx_start <= 0;
        wait_for(tx_byte_ready);
        tx_byte_valid <= 0;
        wait_for(tx_done);
        chk("bit count", ex.size(), i_card.heard.size());
        foreach (ex[i]) chk("air bit", ex[i], i_card.heard[i]);
    endtask
    task automatic test_tx();
        tx_case(KIND_CRC16, 1, 16'h6363, 0, 1, 8'h08);
        tx_case(KIND_CRC16, 2, 16'hA671, 1, 1, 8'h18);
        tx_case(KIND_CRC8, 6, 16'h005A, 1, 1, 8'h0B);
        tx_case(KIND_CRC5, 7, 16'h001F, 0, 1, 8'h0E);
        tx_case(KIND_CRC8, 3, 16'h00FD, 0, 0, 8'h08);
        wreg(FRAME_LEN_ADDR, 8'h00);
        i_card.heard.delete();
        @(posedge clk) tx_start <= 1;
        @(posedge clk) tx_start <= 0;
        wait_for(tx_done);
        chk("lone symbol", 1, tx_symbol);
        chk("no bits", 0, i_card.heard.size());
        $display("transmit test done");
    endtask
    // CRC16 frame from seed FFFF, inverted per setup, optionally spoiled
    task automatic rx_case(input logic [7:0] s, input logic bad, er, input int nf);
        logic [15:0] c = 16'hFFFF;
        logic [7:0] f[$] = '{8'h12, 8'h34};
        foreach (f[i]) for (int j = 0; j < 8; j++) c = nx(c, POLY16_REV, f[i][j]);
        c = c ^ {16{s[1]}} ^ bad;
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        wreg(RX_SETUP_ADDR, s);
        q.delete();
        i_card.answer(f);
        repeat (6) @(posedge clk);
        chk("error flag", er, rx_crc_error);
        chk("fifo count", nf, q.size());
        chk("fifo first", 8'h12, q[0]);
    endtask
    task automatic test_rx();
        rx_case(8'h79, 0, 0, 2);
        rx_case(8'hFB, 0, 0, 4);
        rx_case(8'h79, 1, 1, 2);
        rx_case(8'h78, 1, 1, 4);
        @(posedge clk) rx_error_clear <= 1;
        @(posedge clk) rx_error_clear <= 0;
        rx_case(8'h78, 1, 0, 4);
        $display("receive test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1;
        test_regs();
        test_tx();
        test_rx();
        tally_and_finish();
    end
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin #200000; fails++; tally_and_finish(); end
endmodule // tb_top
`default_nettype wire
